// >>> bss_pkg.sv
// Constants and types shared by the boot strap selector.
`default_nettype none
package bss_pkg;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned STRAP_SETTLE_NS = 1000;
  localparam int unsigned INIT_TIME_NS = 20000;
  localparam int unsigned REFRESH_TIME_NS = 50000;
  localparam int unsigned SECOND_TIME_NS = 20000;
  localparam int unsigned UPDATE_TIME_NS = 50000;
  localparam int unsigned RUNTIME_TIME_NS = 20000;

  // Least times round up to whole cycles and never fall below one.
  function automatic int unsigned cyc_min(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c == 0) ? 1 : c;
  endfunction : cyc_min

  localparam int CNT_W = 12;
  localparam logic [CNT_W-1:0] CNT_SETTLE = CNT_W'(cyc_min(STRAP_SETTLE_NS));
  localparam logic [CNT_W-1:0] CNT_INIT = CNT_W'(cyc_min(INIT_TIME_NS));
  localparam logic [CNT_W-1:0] CNT_REFRESH = CNT_W'(cyc_min(REFRESH_TIME_NS));
  localparam logic [CNT_W-1:0] CNT_SECOND = CNT_W'(cyc_min(SECOND_TIME_NS));
  localparam logic [CNT_W-1:0] CNT_UPDATE = CNT_W'(cyc_min(UPDATE_TIME_NS));
  localparam logic [CNT_W-1:0] CNT_RUNTIME = CNT_W'(cyc_min(RUNTIME_TIME_NS));

  // ---------------------------------------------------------------------------
  // Pins and reset values
  // ---------------------------------------------------------------------------
  localparam int PIN_SEL_A = 0;
  localparam int PIN_SEL_B = 1;
  localparam int PIN_LINK = 2;
  localparam logic [2:0] GPIO_OE_RST = 3'h0;
  localparam logic [2:0] GPIO_OUT_RST = 3'h0;
  localparam logic [2:0] GPIO_PULL_RST = 3'h7;
  localparam logic LINK_USB_RST = 1'b1;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_HELD = 3'h0,
    ST_SAMPLE = 3'h1,
    ST_INIT = 3'h2,
    ST_REFRESH = 3'h3,
    ST_SECOND = 3'h4,
    ST_UPDATE = 3'h5,
    ST_RUNTIME = 3'h6,
    ST_APP = 3'h7
  } bss_state_t;

  typedef enum logic [1:0] {
    BOOT_APP = 2'h0,
    HALT_SECOND = 2'h1,
    HALT_FIRST = 2'h2
  } bss_mode_t;

  function automatic bss_mode_t decode_boot(input logic selA, input logic selB);
    if (selB) begin
      return BOOT_APP;
    end
    return selA ? HALT_SECOND : HALT_FIRST;
  endfunction : decode_boot

endpackage : bss_pkg
`default_nettype wire

// >>> bss_pin_if.sv
// Link between the startup sequencer and the strap pin bank.
`timescale 1ns/1ps
`default_nettype none
interface bss_pin_if;
  logic strapMode;
  logic [2:0] strapVal;
  modport ctrl (output strapMode, input strapVal);
  modport bank (input strapMode, output strapVal);
endinterface : bss_pin_if
`default_nettype wire

// >>> bss_pin_bank.sv
// Strap pins: pulled-up inputs during startup, ordinary GPIO afterwards.
`timescale 1ns/1ps
`default_nettype none
module bss_pin_bank (
  input wire logic ref_clk,
  input wire logic rst_n,
  bss_pin_if.bank pins,
  input wire logic [2:0] padIn,
  input wire logic gpioWe,
  input wire logic [2:0] gpioOutD,
  input wire logic [2:0] gpioOeD,
  input wire logic [2:0] gpioPullD,
  output logic [2:0] padOut,
  output logic [2:0] padOe,
  output logic [2:0] padPull,
  output logic [2:0] gpioIn,
  output logic resetPullUp
);

  logic [2:0] userOut_q, userOut_d, userOe_q, userOe_d, userPull_q, userPull_d;
  logic [2:0] padOut_d, padOe_d, padPull_d, strapVal_q;

  // ---------------------------------------------------------------------------
  // Pin control
  // ---------------------------------------------------------------------------
  always_comb begin
    userOut_d = userOut_q;
    userOe_d = userOe_q;
    userPull_d = userPull_q;
    if (pins.strapMode) begin
      userOut_d = bss_pkg::GPIO_OUT_RST;
      userOe_d = bss_pkg::GPIO_OE_RST;
      userPull_d = bss_pkg::GPIO_PULL_RST;
    end else if (gpioWe) begin
      userOut_d = gpioOutD;
      userOe_d = gpioOeD;
      userPull_d = gpioPullD;
    end
    // After startup the application owns the pins.
    padOut_d = pins.strapMode ? 3'h0 : userOut_q;
    padOe_d = pins.strapMode ? 3'h0 : userOe_q;
    padPull_d = pins.strapMode ? 3'h7 : userPull_q;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      userOut_q <= bss_pkg::GPIO_OUT_RST;
      userOe_q <= bss_pkg::GPIO_OE_RST;
      userPull_q <= bss_pkg::GPIO_PULL_RST;
      padOut <= bss_pkg::GPIO_OUT_RST;
      padOe <= bss_pkg::GPIO_OE_RST;
      padPull <= bss_pkg::GPIO_PULL_RST;
      gpioIn <= 3'h7;
      strapVal_q <= 3'h7;
      resetPullUp <= 1'b1;
    end else begin
      userOut_q <= userOut_d;
      userOe_q <= userOe_d;
      userPull_q <= userPull_d;
      padOut <= padOut_d;
      padOe <= padOe_d;
      padPull <= padPull_d;
      gpioIn <= padIn;
      strapVal_q <= padIn;
      resetPullUp <= 1'b1;
    end
  end

  assign pins.strapVal = strapVal_q;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  resetPull_a: assert property (@(posedge ref_clk) disable iff (!rst_n) resetPullUp)
    else $error("reset pin pull-up dropped");
  strapPull_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pins.strapMode |=> (padPull == 3'h7) && (padOe == 3'h0))
    else $error("strap pins not pulled-up inputs during startup");
  gpioRevert_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!pins.strapMode && gpioWe) ##1 !pins.strapMode |=> padOe == $past(gpioOeD, 2))
    else $error("GPIO direction write not applied after startup");
  gpioDefault_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $fell(pins.strapMode) |=> (padOe == 3'h0) && (padPull == 3'h7))
    else $error("GPIO not input with pull-up after startup");

endmodule : bss_pin_bank
`default_nettype wire

// >>> bss_top.sv
// Startup sequencer: reset pin, boot-select straps and staged boot.
//
// Functional notes
// - While the reset pin is low, stay in reset and run nothing.
// - Releasing the reset pin starts the startup sequence.
// - The reset pin has an internal pull-up.
// - Boot runs first loader, second loader, runtime, then the application.
// - Select B high runs app; A high B low halts second; both low halt first.
// - Both boot-select straps are pulled high during startup.
// - Debug-link strap high picks USB, low picks the first serial port.
// - After startup the three strap pins become ordinary GPIO.
// - GPIO pins come up as inputs with weak pull-ups.
`timescale 1ns/1ps
`default_nettype none
module bss_top (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic resetPinN,
  input wire logic [2:0] strapPadIn,
  input wire logic secondStale,
  input wire logic updateReq,
  input wire logic gpioWe,
  input wire logic [2:0] gpioOutD,
  input wire logic [2:0] gpioOeD,
  input wire logic [2:0] gpioPullD,
  output logic [2:0] strapPadOut,
  output logic [2:0] strapPadOe,
  output logic [2:0] strapPullUp,
  output logic resetPullUp,
  output logic [2:0] gpioIn,
  output logic [2:0] bootStage,
  output logic appRun,
  output logic haltFirst,
  output logic haltSecond,
  output logic debugUsb,
  output logic strapsReleased
);

  // ---------------------------------------------------------------------------
  // Pin bank
  // ---------------------------------------------------------------------------
  bss_pin_if pins ();

  bss_pin_bank u_bank (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pins(pins.bank),
    .padIn(strapPadIn),
    .gpioWe(gpioWe),
    .gpioOutD(gpioOutD),
    .gpioOeD(gpioOeD),
    .gpioPullD(gpioPullD),
    .padOut(strapPadOut),
    .padOe(strapPadOe),
    .padPull(strapPullUp),
    .gpioIn(gpioIn),
    .resetPullUp(resetPullUp)
  );

  // ---------------------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------------------
  bss_pkg::bss_state_t state_q, state_d;
  bss_pkg::bss_mode_t mode_q, mode_d, decodedNow;
  logic [bss_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic linkUsb_q, linkUsb_d;
  logic appRun_d, haltFirst_d, haltSecond_d, released_d;

  assign decodedNow = bss_pkg::decode_boot(pins.strapVal[bss_pkg::PIN_SEL_A],
                                           pins.strapVal[bss_pkg::PIN_SEL_B]);

  // Straps keep their boot role only until they have been sampled.
  assign pins.strapMode = (state_q == bss_pkg::ST_HELD) || (state_q == bss_pkg::ST_SAMPLE);

  always_comb begin
    state_d = state_q;
    mode_d = mode_q;
    linkUsb_d = linkUsb_q;
    cnt_d = (cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;
    // Held in reset while the pin is low.
    if (!resetPinN) begin
      state_d = bss_pkg::ST_HELD;
      cnt_d = '0;
    end else begin
      unique case (state_q)
        bss_pkg::ST_HELD: begin
          state_d = bss_pkg::ST_SAMPLE;
          cnt_d = bss_pkg::CNT_SETTLE;
        end
        // A settle delay gives the board time to steady the straps after release.
        bss_pkg::ST_SAMPLE: begin
          if (cnt_q == '0) begin
            mode_d = decodedNow;
            linkUsb_d = pins.strapVal[bss_pkg::PIN_LINK];
            state_d = bss_pkg::ST_INIT;
            cnt_d = bss_pkg::CNT_INIT;
          end
        end
        // First loader initialises, refreshes if stale, hands over.
        bss_pkg::ST_INIT: begin
          if (cnt_q == '0 && mode_q != bss_pkg::HALT_FIRST) begin
            if (secondStale) begin
              state_d = bss_pkg::ST_REFRESH;
              cnt_d = bss_pkg::CNT_REFRESH;
            end else begin
              state_d = bss_pkg::ST_SECOND;
              cnt_d = bss_pkg::CNT_SECOND;
            end
          end
        end
        bss_pkg::ST_REFRESH: begin
          if (cnt_q == '0) begin
            state_d = bss_pkg::ST_SECOND;
            cnt_d = bss_pkg::CNT_SECOND;
          end
        end
        // Second loader may update runtime and configuration.
        bss_pkg::ST_SECOND: begin
          if (cnt_q == '0 && mode_q != bss_pkg::HALT_SECOND) begin
            if (updateReq) begin
              state_d = bss_pkg::ST_UPDATE;
              cnt_d = bss_pkg::CNT_UPDATE;
            end else begin
              state_d = bss_pkg::ST_RUNTIME;
              cnt_d = bss_pkg::CNT_RUNTIME;
            end
          end
        end
        bss_pkg::ST_UPDATE: begin
          if (cnt_q == '0) begin
            state_d = bss_pkg::ST_RUNTIME;
            cnt_d = bss_pkg::CNT_RUNTIME;
          end
        end
        bss_pkg::ST_RUNTIME: begin
          if (cnt_q == '0) begin
            state_d = bss_pkg::ST_APP;
          end
        end
        bss_pkg::ST_APP: begin
          state_d = bss_pkg::ST_APP;
        end
      endcase
    end
    appRun_d = (state_d == bss_pkg::ST_APP);
    // Halt indications follow the decoded selection.
    haltFirst_d = (state_d == bss_pkg::ST_INIT) && (cnt_d == '0)
                  && (mode_d == bss_pkg::HALT_FIRST);
    haltSecond_d = (state_d == bss_pkg::ST_SECOND) && (cnt_d == '0)
                   && (mode_d == bss_pkg::HALT_SECOND);
    released_d = (state_d != bss_pkg::ST_HELD) && (state_d != bss_pkg::ST_SAMPLE);
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= bss_pkg::ST_HELD;
      mode_q <= bss_pkg::BOOT_APP;
      cnt_q <= '0;
      linkUsb_q <= bss_pkg::LINK_USB_RST;
      appRun <= 1'b0;
      haltFirst <= 1'b0;
      haltSecond <= 1'b0;
      debugUsb <= bss_pkg::LINK_USB_RST;
      strapsReleased <= 1'b0;
    end else begin
      state_q <= state_d;
      mode_q <= mode_d;
      cnt_q <= cnt_d;
      linkUsb_q <= linkUsb_d;
      appRun <= appRun_d;
      haltFirst <= haltFirst_d;
      haltSecond <= haltSecond_d;
      debugUsb <= linkUsb_d;
      strapsReleased <= released_d;
    end
  end

  assign bootStage = state_q;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  // Cycles spent in the settle window, counted so the sampling check needs no long repetition.
  logic [bss_pkg::CNT_W-1:0] settleAge_q, settleAge_d;

  always_comb begin
    settleAge_d = (state_q == bss_pkg::ST_SAMPLE) ? settleAge_q + 1'b1 : '0;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      settleAge_q <= '0;
    end else begin
      settleAge_q <= settleAge_d;
    end
  end

  heldInReset_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !resetPinN |=> (state_q == bss_pkg::ST_HELD) && !appRun)
    else $error("sequencer not held while reset pin low");
  releaseStart_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_q == bss_pkg::ST_HELD) && resetPinN |=> state_q == bss_pkg::ST_SAMPLE)
    else $error("startup did not begin on reset release");
  initEntry_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $changed(state_q) && (state_q == bss_pkg::ST_INIT)
      |-> $past(state_q) == bss_pkg::ST_SAMPLE)
    else $error("first loader entered out of order");
  appEntry_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(appRun) |-> $past(state_q, 2) == bss_pkg::ST_RUNTIME)
    else $error("application started without runtime stage");
  bootDecode_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_q == bss_pkg::ST_SAMPLE) && (cnt_q == '0) && resetPinN
      |=> mode_q == $past(decodedNow))
    else $error("boot selection decoded wrongly");
  haltStay_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    haltFirst && resetPinN |=> haltFirst && (state_q == bss_pkg::ST_INIT))
    else $error("first loader halt not kept");
  linkSelect_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_q == bss_pkg::ST_SAMPLE) && (cnt_q == '0) && resetPinN
      |=> debugUsb == $past(pins.strapVal[bss_pkg::PIN_LINK]))
    else $error("debug link selection wrong");
  sampleWindow_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_q == bss_pkg::ST_SAMPLE) && (settleAge_q == bss_pkg::CNT_SETTLE) && resetPinN
      |=> strapsReleased)
    else $error("straps not sampled after settle time");

  appReached_c: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(appRun));
  haltFirst_c: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(haltFirst));
  haltSecond_c: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(haltSecond));
  refresh_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
    state_q == bss_pkg::ST_REFRESH);

endmodule : bss_top
`default_nettype wire

// >>> bss_board_model.sv
// Board side of the startup block: reset circuit and strap pin drivers.
`timescale 1ns/1ps
`default_nettype none
module bss_board_model (
  input wire logic ref_clk,
  input wire logic holdReset,
  input wire logic [2:0] strapDrive,
  input wire logic [2:0] strapLevel,
  input wire logic [2:0] devOut,
  input wire logic [2:0] devOe,
  input wire logic [2:0] devPull,
  input wire logic devResetPull,
  output logic resetPinN,
  output logic [2:0] padLevel
);
  // An undriven pad with no pull-up floats; toggle it so a stale value never passes.
  logic [3:0] floatQ = 4'h5;
  always @(posedge ref_clk) begin
    floatQ <= ~floatQ;
  end
  // ---------------------------------------------------------------------------
  // Pad resolution
  // ---------------------------------------------------------------------------
  // Straps held by board.
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (devOe[i]) begin
        padLevel[i] = devOut[i];
      end else if (strapDrive[i]) begin
        padLevel[i] = strapLevel[i];
      end else begin
        padLevel[i] = devPull[i] ? 1'b1 : floatQ[i];
      end
    end
    resetPinN = holdReset ? 1'b0 : (devResetPull ? 1'b1 : floatQ[3]);
  end
endmodule : bss_board_model
`default_nettype wire

// >>> tb_top.sv
// Self-checking testbench of the boot strap selector.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic holdReset = 1'b1;
  logic [2:0] strapDrive = 3'h0;
  logic [2:0] strapLevel = 3'h0;
  logic secondStale = 1'b0;
  logic updateReq = 1'b0;
  logic gpioWe = 1'b0;
  logic [2:0] gpioOutD = 3'h0;
  logic [2:0] gpioOeD = 3'h0;
  logic [2:0] gpioPullD = 3'h7;
  logic resetPinN;
  logic [2:0] strapPadIn, strapPadOut, strapPadOe, strapPullUp, gpioIn, bootStage;
  logic resetPullUp, appRun, haltFirst, haltSecond, debugUsb, strapsReleased;
  int badCount = 0;
  int testsRun = 0;
  int cycles = 0;

  always #25 ref_clk = ~ref_clk;

  bss_board_model bss_board_model_inst (.ref_clk(ref_clk), .holdReset(holdReset),
    .strapDrive(strapDrive), .strapLevel(strapLevel), .devOut(strapPadOut),
    .devOe(strapPadOe), .devPull(strapPullUp), .devResetPull(resetPullUp),
    .resetPinN(resetPinN), .padLevel(strapPadIn));

  bss_top bss_top_inst (.ref_clk(ref_clk), .rst_n(rst_n), .resetPinN(resetPinN),
    .strapPadIn(strapPadIn), .secondStale(secondStale), .updateReq(updateReq),
    .gpioWe(gpioWe), .gpioOutD(gpioOutD), .gpioOeD(gpioOeD), .gpioPullD(gpioPullD),
    .strapPadOut(strapPadOut), .strapPadOe(strapPadOe), .strapPullUp(strapPullUp),
    .resetPullUp(resetPullUp), .gpioIn(gpioIn), .bootStage(bootStage), .appRun(appRun),
    .haltFirst(haltFirst), .haltSecond(haltSecond), .debugUsb(debugUsb),
    .strapsReleased(strapsReleased));

  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    testsRun++;
    if (seen !== exp) begin
      badCount++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", testsRun, badCount);
    if (badCount == 0 && testsRun > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude

  // Hang guard: the longest run is five boots of about 3400 cycles each.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 25000) begin
      badCount++;
      conclude();
    end
  end

  task automatic reset_values();
    check("stage", 24'(bootStage), 24'h0);
    check("released", 24'(strapsReleased), 24'h0);
    check("run", 24'({appRun, haltFirst, haltSecond}), 24'h0);
    check("pinOe", 24'(strapPadOe), 24'h0);
    check("pull", 24'(strapPullUp), 24'h7);
    check("resetPull", 24'(resetPullUp), 24'h1);
  endtask : reset_values

  // One startup; expSeq packs the stage codes visited, flags are {app, halt2, halt1, usb}.
  task automatic boot_case(input logic [2:0] drv, input logic [2:0] lvl, input logic stale,
                           input logic upd, input logic [23:0] expSeq, input logic [3:0] flags);
    logic [23:0] seq;
    logic [2:0] prev;
    int sampleCnt;
    seq = 24'h0;
    prev = 3'h0;
    sampleCnt = 0;
    @(negedge ref_clk);
    holdReset = 1'b1;
    strapDrive = drv;
    strapLevel = lvl;
    secondStale = stale;
    updateReq = upd;
    repeat (3) @(negedge ref_clk);
    reset_values();
    holdReset = 1'b0;
    repeat (3400) begin
      @(negedge ref_clk);
      if (bootStage === 3'h1) begin
        sampleCnt++;
      end
      if (bootStage !== prev) begin
        seq = {seq[20:0], bootStage};
        prev = bootStage;
      end
    end
    check("sample", 24'(sampleCnt), 24'h15);
    check("stages", seq, expSeq);
    check("mode", 24'({appRun, haltSecond, haltFirst}), 24'(flags[3:1]));
    check("link", 24'(debugUsb), 24'(flags[0]));
    check("released", 24'(strapsReleased), 24'h1);
  endtask : boot_case

  // Pulling the reset pin low mid-boot must drop everything back to held.
  task automatic abort_boot();
    @(negedge ref_clk);
    holdReset = 1'b1;
    strapDrive = 3'h0;
    repeat (2) @(negedge ref_clk);
    holdReset = 1'b0;
    repeat (100) @(negedge ref_clk);
    check("inInit", 24'(bootStage), 24'h2);
    holdReset = 1'b1;
    @(negedge ref_clk);
    reset_values();
    repeat (50) @(negedge ref_clk);
    check("stillHeld", 24'(bootStage), 24'h0);
  endtask : abort_boot

  task automatic gpio_write(input logic [2:0] oe, input logic [2:0] out, input logic [2:0] pull);
    @(negedge ref_clk);
    gpioWe = 1'b1;
    gpioOeD = oe;
    gpioOutD = out;
    gpioPullD = pull;
    @(negedge ref_clk);
    gpioWe = 1'b0;
    repeat (2) @(negedge ref_clk);
  endtask : gpio_write

  // Writes are refused while held: the pins stay inputs with pull-ups.
  task automatic gpio_use();
    gpio_write(3'h7, 3'h5, 3'h0);
    check("heldOe", 24'(strapPadOe), 24'h0);
    check("heldPull", 24'(strapPullUp), 24'h7);
  endtask : gpio_use

  task automatic gpio_after();
    strapDrive = 3'h0;
    gpio_write(3'h7, 3'h5, 3'h0);
    check("gpioOe", 24'(strapPadOe), 24'h7);
    check("gpioOut", 24'(strapPadOut), 24'h5);
    check("gpioPull", 24'(strapPullUp), 24'h0);
    check("gpioIn", 24'(gpioIn), 24'h5);
    gpio_write(3'h0, 3'h0, 3'h7);
    check("gpioRead", 24'(gpioIn), 24'h7);
  endtask : gpio_after

  initial begin
    repeat (4) @(negedge ref_clk);
    rst_n = 1'b1;
    reset_values();
    gpio_use();
    boot_case(3'h0, 3'h0, 1'b0, 1'b0, 24'h001537, 4'h9);
    boot_case(3'h7, 3'h2, 1'b1, 1'b1, 24'h053977, 4'h8);
    boot_case(3'h7, 3'h5, 1'b0, 1'b0, 24'h000054, 4'h5);
    boot_case(3'h7, 3'h0, 1'b0, 1'b0, 24'h00000A, 4'h2);
    abort_boot();
    boot_case(3'h7, 3'h6, 1'b0, 1'b0, 24'h001537, 4'h9);
    gpio_after();
    conclude();
  end
endmodule : tb_top
`default_nettype wire
